/* File: include/ccs_pkg.sv */
// Purpose: shared constants and types of the current transformer circuit supervision block
// Assumes: currents in units of 0.01 x nominal, ratios in units of 0.01 percent
// Notes:   setting defaults are the reset values of all eight setting groups
package ccs_pkg;
	localparam int CCS_MAG_W    = 16;
	localparam int CCS_SET_W    = 16;
	localparam int CCS_GROUPS   = 8;
	localparam int CCS_GRP_W    = 3;
	localparam int CCS_FIELDS   = 6;
	localparam int CCS_FLD_W    = 3;
	localparam int CCS_PHASES   = 3;
	localparam int CCS_CNT_W    = 16;
	localparam int CCS_TS_W     = 32;
	localparam int CCS_SUM_W    = 19;

	// field index within one setting group
	localparam logic [CCS_FLD_W-1:0] CCS_FLD_UPPER = 3'h0;
	localparam logic [CCS_FLD_W-1:0] CCS_FLD_LOWER = 3'h1;
	localparam logic [CCS_FLD_W-1:0] CCS_FLD_MINMAX = 3'h2;
	localparam logic [CCS_FLD_W-1:0] CCS_FLD_SEQ   = 3'h3;
	localparam logic [CCS_FLD_W-1:0] CCS_FLD_SUM   = 3'h4;
	localparam logic [CCS_FLD_W-1:0] CCS_FLD_DELAY = 3'h5;

	localparam logic [CCS_SET_W-1:0] CCS_DEF_UPPER  = 16'h0078;
	localparam logic [CCS_SET_W-1:0] CCS_DEF_LOWER  = 16'h000a;
	localparam logic [CCS_SET_W-1:0] CCS_DEF_MINMAX = 16'h03e8;
	localparam logic [CCS_SET_W-1:0] CCS_DEF_SEQ    = 16'h1324;
	localparam logic [CCS_SET_W-1:0] CCS_DEF_SUM    = 16'h000a;
	localparam logic [CCS_SET_W-1:0] CCS_DEF_DELAY  = 16'h0064;

	localparam logic [1:0] CCS_RES_NONE = 2'h0;
	localparam logic [1:0] CCS_RES_A    = 2'h1;
	localparam logic [1:0] CCS_RES_B    = 2'h2;

	localparam logic [31:0] CCS_HYST_PCT  = 32'h0000_0064;
	localparam logic [31:0] CCS_HYST_LO   = 32'h0000_0061;
	localparam logic [31:0] CCS_HYST_HI   = 32'h0000_0067;
	localparam logic [31:0] CCS_RATIO_FULL = 32'h0000_2710;

	localparam int CCS_CLK_PERIOD_NS  = 5;
	localparam int CCS_MS_NS          = 1000000;
	localparam int CCS_CYC_PER_MS     = CCS_MS_NS / CCS_CLK_PERIOD_NS;
	localparam int CCS_MEAS_PERIOD_MS = 5;
	localparam int CCS_PREFAULT_MS    = 20;
	localparam int CCS_PREFAULT_N     = CCS_PREFAULT_MS / CCS_MEAS_PERIOD_MS;
	localparam int CCS_PREFAULT_SHIFT = 2;

	typedef enum logic [1:0] {
		CCS_IDLE   = 2'b00,
		CCS_TIMING = 2'b01,
		CCS_ALARM  = 2'b11
	} ccs_state_t;
endpackage

/* File: design/ccs_avg.sv */
// Purpose: sliding average over the last four measurement samples of one channel
// Assumes: sample_valid pulses once per measurement update
// Notes:   history is zero after reset, so the first 20 ms average reads low
`timescale 1ns/1ps
module ccs_avg (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           sample_valid,
	input  wire logic [ccs_pkg::CCS_MAG_W-1:0]  sample,
	output logic      [ccs_pkg::CCS_MAG_W-1:0]  avg
);
	import ccs_pkg::*;

	logic [CCS_MAG_W-1:0] hist_reg [CCS_PREFAULT_N];
	logic [CCS_MAG_W+CCS_PREFAULT_SHIFT-1:0] sum;

	genvar gi;
	generate
		for (gi = 0; gi < CCS_PREFAULT_N; gi++) begin : g_hist
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					hist_reg[gi] <= '0;
				end else if (sample_valid) begin
					hist_reg[gi] <= (gi == 0) ? sample : hist_reg[(gi == 0) ? 0 : gi-1];
				end
			end
		end
	endgenerate

	always_comb begin
		sum = '0;
		for (int i = 0; i < CCS_PREFAULT_N; i++) begin
			sum = sum + (CCS_MAG_W+CCS_PREFAULT_SHIFT)'(hist_reg[i]);
		end
	end

	assign avg = sum[CCS_MAG_W+CCS_PREFAULT_SHIFT-1:CCS_PREFAULT_SHIFT];
endmodule

/* File: design/ccs_supervision.sv */
// Purpose: current transformer secondary circuit supervision, alarm, blocking, events, counters
// Assumes: measurement ports and MEAS_VALID come from logic on CLK; BLOCK_IN, GROUP_SEL are pins
// Notes:   comparator flags update only on MEAS_VALID; timing runs on a 1 ms tick
//
// Contract
// - alarm only while no phase current is above the upper threshold
// - at least one phase current above the lower threshold
// - at least one phase current below the lower threshold at once
// - min over max phase ratio must be below the ratio setting
// - negative over positive sequence ratio must exceed its setting
// - with residual in use, phase sum with residual must exceed sum threshold
// - alarm only after all conditions held continuously for the alarm delay
// - eight setting groups, one common group selection
// - blocking, group and settings may change while supervision keeps running
// - alarm and blocked outputs; timestamped event on each edge, 1 ms resolution
// - cumulative alarm and blocked counters, cleared by a reset command
// - residual channel selectable as none, input a or input b
// - pre-fault value is a 20 ms average ending at the start event
// - current comparisons release at 97 or 103 percent of the threshold
// - polarity setting adds or subtracts residual from the phase sum
`timescale 1ns/1ps
module ccs_supervision #(
	parameter int CYC_PER_MS = ccs_pkg::CCS_CYC_PER_MS
) (
	input  wire logic                           CLK,
	input  wire logic                           RST_N,
	input  wire logic                           MEAS_VALID,
	input  wire logic [ccs_pkg::CCS_MAG_W-1:0]  PHASE_A_RMS,
	input  wire logic [ccs_pkg::CCS_MAG_W-1:0]  PHASE_B_RMS,
	input  wire logic [ccs_pkg::CCS_MAG_W-1:0]  PHASE_C_RMS,
	input  wire logic [ccs_pkg::CCS_MAG_W-1:0]  RESIDUAL_A_RMS,
	input  wire logic [ccs_pkg::CCS_MAG_W-1:0]  RESIDUAL_B_RMS,
	input  wire logic [ccs_pkg::CCS_MAG_W-1:0]  POSITIVE_SEQUENCE_CURRENT,
	input  wire logic [ccs_pkg::CCS_MAG_W-1:0]  NEGATIVE_SEQUENCE_CURRENT,
	input  wire logic                           BLOCK_IN,
	input  wire logic [ccs_pkg::CCS_GRP_W-1:0]  GROUP_SEL,
	input  wire logic [1:0]                     RESIDUAL_SELECT,
	input  wire logic                           RESIDUAL_POLARITY,
	input  wire logic                           CFG_WE,
	input  wire logic [ccs_pkg::CCS_GRP_W-1:0]  CFG_GROUP,
	input  wire logic [ccs_pkg::CCS_FLD_W-1:0]  CFG_FIELD,
	input  wire logic [ccs_pkg::CCS_SET_W-1:0]  CFG_DATA,
	input  wire logic                           CNT_CLEAR,
	output logic                                ALARM,
	output logic                                BLOCKED,
	output logic                                EVT_VALID,
	output logic [1:0]                          EVT_SOURCE,
	output logic [1:0]                          EVT_LEVEL,
	output logic [ccs_pkg::CCS_TS_W-1:0]        EVT_TIME,
	output logic [ccs_pkg::CCS_CNT_W-1:0]       ALARM_COUNT,
	output logic [ccs_pkg::CCS_CNT_W-1:0]       BLOCKED_COUNT,
	output logic [ccs_pkg::CCS_MAG_W-1:0]       PREFAULT_A,
	output logic [ccs_pkg::CCS_MAG_W-1:0]       PREFAULT_B,
	output logic [ccs_pkg::CCS_MAG_W-1:0]       PREFAULT_C
);
	import ccs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	logic                 rst_meta_reg;
	logic                 rst_n;
	logic                 block_meta_reg;
	logic                 block_reg;
	logic [CCS_GRP_W-1:0] grp_meta_reg;
	logic [CCS_GRP_W-1:0] grp_reg;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			block_meta_reg <= 1'b0;
			block_reg      <= 1'b0;
			grp_meta_reg   <= '0;
			grp_reg        <= '0;
		end else begin
			block_meta_reg <= BLOCK_IN;
			block_reg      <= block_meta_reg;
			grp_meta_reg   <= GROUP_SEL;
			grp_reg        <= grp_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// setting groups, writable at any time without stopping supervision
	logic [CCS_SET_W-1:0] set_reg [CCS_GROUPS][CCS_FIELDS];
	logic [CCS_SET_W-1:0] def_val [CCS_FIELDS];

	assign def_val = '{CCS_DEF_UPPER, CCS_DEF_LOWER, CCS_DEF_MINMAX,
	                   CCS_DEF_SEQ, CCS_DEF_SUM, CCS_DEF_DELAY};

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			for (int g = 0; g < CCS_GROUPS; g++) begin
				set_reg[g] <= '{CCS_DEF_UPPER, CCS_DEF_LOWER, CCS_DEF_MINMAX,
				                CCS_DEF_SEQ, CCS_DEF_SUM, CCS_DEF_DELAY};
			end
		end else if (CFG_WE && (32'(CFG_FIELD) < CCS_FIELDS)) begin
			set_reg[CFG_GROUP][CFG_FIELD] <= CFG_DATA;
		end
	end

	// one common selection picks the active group
	wire [CCS_SET_W-1:0] upper_th  = set_reg[grp_reg][CCS_FLD_UPPER];
	wire [CCS_SET_W-1:0] lower_th  = set_reg[grp_reg][CCS_FLD_LOWER];
	wire [CCS_SET_W-1:0] minmax_th = set_reg[grp_reg][CCS_FLD_MINMAX];
	wire [CCS_SET_W-1:0] seq_th    = set_reg[grp_reg][CCS_FLD_SEQ];
	wire [CCS_SET_W-1:0] sum_th    = set_reg[grp_reg][CCS_FLD_SUM];
	wire [CCS_SET_W-1:0] delay_ms  = set_reg[grp_reg][CCS_FLD_DELAY];

	////////////////////////////////////////////////////////////////////////////////
	// per-phase comparators with hysteresis, and pre-fault averages
	logic [CCS_MAG_W-1:0] ph       [CCS_PHASES];
	logic [CCS_MAG_W-1:0] ph_avg   [CCS_PHASES];
	logic [CCS_PHASES-1:0] hi_reg;
	logic [CCS_PHASES-1:0] lo_abv_reg;
	logic [CCS_PHASES-1:0] lo_blw_reg;

	assign ph[0] = PHASE_A_RMS;
	assign ph[1] = PHASE_B_RMS;
	assign ph[2] = PHASE_C_RMS;

	wire [31:0] up_rel  = 32'(upper_th) * CCS_HYST_LO;
	wire [31:0] lo_rel  = 32'(lower_th) * CCS_HYST_LO;
	wire [31:0] lo_relh = 32'(lower_th) * CCS_HYST_HI;

	genvar gi;
	generate
		for (gi = 0; gi < CCS_PHASES; gi++) begin : g_phase
			wire [31:0] m_pct = 32'(ph[gi]) * CCS_HYST_PCT;
			wire hi_nx  = hi_reg[gi] ? !(m_pct < up_rel) : (ph[gi] > upper_th);
			wire abv_nx = lo_abv_reg[gi] ? !(m_pct < lo_rel) : (ph[gi] > lower_th);
			wire blw_nx = lo_blw_reg[gi] ? !(m_pct > lo_relh) : (ph[gi] < lower_th);

			always_ff @(posedge CLK or negedge rst_n) begin
				if (!rst_n) begin
					hi_reg[gi]     <= 1'b0;
					lo_abv_reg[gi] <= 1'b0;
					lo_blw_reg[gi] <= 1'b0;
				end else if (MEAS_VALID) begin
					hi_reg[gi]     <= hi_nx;
					lo_abv_reg[gi] <= abv_nx;
					lo_blw_reg[gi] <= blw_nx;
				end
			end

			ccs_avg u_avg (
				.clk          (CLK),
				.rst_n        (rst_n),
				.sample_valid (MEAS_VALID),
				.sample       (ph[gi]),
				.avg          (ph_avg[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// ratio and sum conditions
	wire [CCS_MAG_W-1:0] ph_min_ab = (ph[0] < ph[1]) ? ph[0] : ph[1];
	wire [CCS_MAG_W-1:0] ph_max_ab = (ph[0] > ph[1]) ? ph[0] : ph[1];
	wire [CCS_MAG_W-1:0] ph_min    = (ph[2] < ph_min_ab) ? ph[2] : ph_min_ab;
	wire [CCS_MAG_W-1:0] ph_max    = (ph[2] > ph_max_ab) ? ph[2] : ph_max_ab;

	// cross-multiplied to avoid a divider; an all-zero max never counts as low ratio
	wire minmax_nx = (ph_max != '0) &&
	                 ((32'(ph_min) * CCS_RATIO_FULL) < (32'(minmax_th) * 32'(ph_max)));
	wire seq_nx    = (32'(NEGATIVE_SEQUENCE_CURRENT) * CCS_RATIO_FULL) >
	                 (32'(seq_th) * 32'(POSITIVE_SEQUENCE_CURRENT));

	wire res_used = (RESIDUAL_SELECT == CCS_RES_A) || (RESIDUAL_SELECT == CCS_RES_B);
	wire [CCS_MAG_W-1:0] res_mag = (RESIDUAL_SELECT == CCS_RES_B) ? RESIDUAL_B_RMS :
	                                                                 RESIDUAL_A_RMS;
	wire signed [CCS_SUM_W-1:0] ph_sum = CCS_SUM_W'(ph[0]) + CCS_SUM_W'(ph[1]) + CCS_SUM_W'(ph[2]);
	wire signed [CCS_SUM_W-1:0] tot    = RESIDUAL_POLARITY ? (ph_sum - CCS_SUM_W'(res_mag)) :
	                                                         (ph_sum + CCS_SUM_W'(res_mag));
	wire [CCS_SUM_W-1:0] tot_abs = tot[CCS_SUM_W-1] ? CCS_SUM_W'(-tot) : CCS_SUM_W'(tot);
	wire [31:0] tot_pct = 32'(tot_abs) * CCS_HYST_PCT;
	wire [31:0] sum_rel = 32'(sum_th) * CCS_HYST_LO;

	logic minmax_reg;
	logic seq_reg;
	logic sum_reg;
	wire  sum_nx = sum_reg ? !(tot_pct < sum_rel) : (32'(tot_abs) > 32'(sum_th));

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			minmax_reg <= 1'b0;
			seq_reg    <= 1'b0;
			sum_reg    <= 1'b0;
		end else if (MEAS_VALID) begin
			minmax_reg <= minmax_nx;
			seq_reg    <= seq_nx;
			sum_reg    <= sum_nx;
		end
	end

	wire cond_all = ~|hi_reg &
	                |lo_abv_reg &
	                |lo_blw_reg &
	                minmax_reg & seq_reg &
	                (!res_used | sum_reg);

	////////////////////////////////////////////////////////////////////////////////
	// millisecond tick, timestamp and alarm delay
	logic [31:0]         div_reg;
	logic [CCS_TS_W-1:0] ts_reg;
	wire                 ms_tick = (div_reg == 32'(CYC_PER_MS - 1));

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= '0;
			ts_reg  <= '0;
		end else begin
			div_reg <= ms_tick ? '0 : div_reg + 32'h0000_0001;
			ts_reg  <= ms_tick ? ts_reg + 32'h0000_0001 : ts_reg;
		end
	end

	ccs_state_t          state_reg;
	ccs_state_t          state_next;
	logic [CCS_SET_W-1:0] dly_reg;
	logic [CCS_SET_W-1:0] dly_next;
	wire                  dly_done = (dly_reg >= delay_ms);

	always_comb begin
		state_next = state_reg;
		dly_next   = dly_reg;
		unique case (state_reg)
			CCS_IDLE: begin
				dly_next = '0;
				if (cond_all) begin
					state_next = CCS_TIMING;
				end
			end
			CCS_TIMING: begin
				if (!cond_all) begin
					state_next = CCS_IDLE;
					dly_next   = '0;
				end else if (dly_done) begin
					state_next = CCS_ALARM;
				end else if (ms_tick) begin
					dly_next = dly_reg + 16'h0001;
				end
			end
			CCS_ALARM: begin
				if (!cond_all) begin
					state_next = CCS_IDLE;
					dly_next   = '0;
				end
			end
			default: begin
				state_next = CCS_IDLE;
				dly_next   = '0;
			end
		endcase
		if (block_reg) begin
			state_next = CCS_IDLE;
			dly_next   = '0;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= CCS_IDLE;
			dly_reg   <= '0;
		end else begin
			state_reg <= state_next;
			dly_reg   <= dly_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, events, counters, pre-fault capture
	wire alarm_next   = (state_next == CCS_ALARM);
	wire alarm_rise   = alarm_next & ~ALARM;
	wire blocked_rise = block_reg & ~BLOCKED;
	wire [1:0] chg    = {block_reg ^ BLOCKED, alarm_next ^ ALARM};

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ALARM      <= 1'b0;
			BLOCKED    <= 1'b0;
			EVT_VALID  <= 1'b0;
			EVT_SOURCE <= '0;
			EVT_LEVEL  <= '0;
			EVT_TIME   <= '0;
		end else begin
			ALARM      <= alarm_next;
			BLOCKED    <= block_reg;
			EVT_VALID  <= |chg;
			EVT_SOURCE <= chg;
			EVT_LEVEL  <= {block_reg, alarm_next};
			EVT_TIME   <= ts_reg;
		end
	end

	// an edge in the clearing cycle still counts: the count restarts at one
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ALARM_COUNT   <= '0;
			BLOCKED_COUNT <= '0;
		end else begin
			if (CNT_CLEAR) begin
				ALARM_COUNT <= alarm_rise ? 16'h0001 : '0;
			end else if (alarm_rise) begin
				ALARM_COUNT <= ALARM_COUNT + 16'h0001;
			end
			if (CNT_CLEAR) begin
				BLOCKED_COUNT <= blocked_rise ? 16'h0001 : '0;
			end else if (blocked_rise) begin
				BLOCKED_COUNT <= BLOCKED_COUNT + 16'h0001;
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PREFAULT_A <= '0;
			PREFAULT_B <= '0;
			PREFAULT_C <= '0;
		end else if (alarm_rise) begin
			PREFAULT_A <= ph_avg[0];
			PREFAULT_B <= ph_avg[1];
			PREFAULT_C <= ph_avg[2];
		end
	end
endmodule

/* File: verif/ccs_frontend_model.sv */
// Purpose: measurement front end model, one sample set per update period
// Assumes: bench values are loaded at the issuing edge
// Notes:   between updates the outputs carry inverted data
`timescale 1ns/1ps
module ccs_frontend_model #(
	parameter int PERIOD = 50
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [6:0][15:0] val_in,
	output logic                  meas_valid,
	output logic      [6:0][15:0] val_out
);
	int unsigned      cnt_reg;
	logic [6:0][15:0] val_reg;
	logic             last_w;

	assign last_w = (cnt_reg == PERIOD - 1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg    <= 32'h0;
			meas_valid <= 1'b0;
			val_reg    <= '0;
		end else begin
			meas_valid <= last_w;
			cnt_reg    <= last_w ? 32'h0 : cnt_reg + 32'h1;
			if (last_w) begin
				val_reg <= val_in;
			end
		end
	end

	// stale data inverted so a late sample cannot match by luck
	assign val_out = meas_valid ? val_reg : ~val_reg;
endmodule

/* File: verif/ccs_supervision_assertions.sv */
// Purpose: port checks of the supervision block
// Assumes: one clock domain, RST_N low disables all checks
// Notes:   setting values are not visible here, so alarm timing is judged by the bench
`timescale 1ns/1ps
module ccs_sup_assertions (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        BLOCK_IN,
	input wire logic        CNT_CLEAR,
	input wire logic        ALARM,
	input wire logic        BLOCKED,
	input wire logic        EVT_VALID,
	input wire logic [1:0]  EVT_SOURCE,
	input wire logic [1:0]  EVT_LEVEL,
	input wire logic [15:0] ALARM_COUNT,
	input wire logic [15:0] BLOCKED_COUNT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_block_held;
		BLOCK_IN [*4];
	endsequence
	sequence s_block_free;
		!BLOCK_IN [*4];
	endsequence
	sequence s_clear_quiet;
		CNT_CLEAR ##1 (!$rose(ALARM) && !$rose(BLOCKED));
	endsequence

	a_no_alarm_blocked: assert property (BLOCKED |-> !ALARM)
		else $error("alarm high while blocked");
	a_block_raise: assert property (s_block_held |=> BLOCKED)
		else $error("blocked missing after block input");
	a_block_release: assert property (s_block_free |=> !BLOCKED)
		else $error("blocked stays after release");
	a_event_flag: assert property (EVT_VALID == ($changed(ALARM) || $changed(BLOCKED)))
		else $error("event flag does not match output change");
	a_event_source: assert property (EVT_VALID |-> EVT_SOURCE == {$changed(BLOCKED),
		$changed(ALARM)} && EVT_LEVEL == {BLOCKED, ALARM})
		else $error("event source or level wrong");
	a_alarm_count: assert property ($rose(ALARM) |-> ALARM_COUNT == ($past(CNT_CLEAR) ?
		16'h0001 : $past(ALARM_COUNT) + 16'h0001))
		else $error("alarm count not advanced");
	a_blocked_count: assert property ($rose(BLOCKED) |-> BLOCKED_COUNT == ($past(CNT_CLEAR) ?
		16'h0001 : $past(BLOCKED_COUNT) + 16'h0001))
		else $error("blocked count not advanced");
	a_count_hold: assert property (!$rose(ALARM) && !$rose(BLOCKED) && !$past(CNT_CLEAR)
		|-> $stable(ALARM_COUNT) && $stable(BLOCKED_COUNT))
		else $error("count moved without cause");
	a_count_clear: assert property (s_clear_quiet |-> ALARM_COUNT == 16'h0 &&
		BLOCKED_COUNT == 16'h0)
		else $error("counts not cleared");
endmodule

/* File: verif/test_ccs_supervision.sv */
// Purpose: self-checking bench of the supervision block
// Assumes: 10 cycles per ms, so one update period is 50 cycles
// Notes:   group 0 delay set to 2 ms to keep the run short
`timescale 1ns/1ps
module test_ccs_supervision;
	import ccs_pkg::*;
	localparam int CYC = 10;
	localparam int PER = 5 * CYC;
	logic             clk, rst_n, meas_valid, block_in, polarity, cfg_we, cnt_clear;
	logic [6:0][15:0] meas_val, meas_out;
	logic [2:0]       group_sel, cfg_group, cfg_field;
	logic [1:0]       res_sel, evt_source, evt_level;
	logic [15:0]      cfg_data, alarm_count, blocked_count, prefault_a, prefault_b, prefault_c;
	logic [31:0]      evt_time;
	logic             alarm, blocked, evt_valid;
	int               error_cnt, checks;

	ccs_frontend_model #(.PERIOD(PER)) u_front (.clk(clk), .rst_n(rst_n), .val_in(meas_val),
		.meas_valid(meas_valid), .val_out(meas_out));
	ccs_supervision #(.CYC_PER_MS(CYC)) uut (.CLK(clk), .RST_N(rst_n), .MEAS_VALID(meas_valid),
		.PHASE_A_RMS(meas_out[0]), .PHASE_B_RMS(meas_out[1]), .PHASE_C_RMS(meas_out[2]),
		.RESIDUAL_A_RMS(meas_out[3]), .RESIDUAL_B_RMS(meas_out[4]),
		.POSITIVE_SEQUENCE_CURRENT(meas_out[5]), .NEGATIVE_SEQUENCE_CURRENT(meas_out[6]),
		.BLOCK_IN(block_in), .GROUP_SEL(group_sel), .RESIDUAL_SELECT(res_sel),
		.RESIDUAL_POLARITY(polarity), .CFG_WE(cfg_we), .CFG_GROUP(cfg_group),
		.CFG_FIELD(cfg_field), .CFG_DATA(cfg_data), .CNT_CLEAR(cnt_clear), .ALARM(alarm),
		.BLOCKED(blocked), .EVT_VALID(evt_valid), .EVT_SOURCE(evt_source),
		.EVT_LEVEL(evt_level), .EVT_TIME(evt_time), .ALARM_COUNT(alarm_count),
		.BLOCKED_COUNT(blocked_count), .PREFAULT_A(prefault_a), .PREFAULT_B(prefault_b),
		.PREFAULT_C(prefault_c));

	always #2.5 clk = ~clk;
	////////////////////////////////////////
	task automatic stop_test;
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cfg(input logic [2:0] g, input logic [2:0] f, input logic [15:0] d);
		@(negedge clk);
		{cfg_we, cfg_group, cfg_field, cfg_data} = {1'b1, g, f, d};
		@(negedge clk);
		cfg_we = 1'b0;
	endtask
	task automatic meas(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
		input logic [15:0] neg);
		@(negedge clk);
		{meas_val[0], meas_val[1], meas_val[2], meas_val[6]} = {a, b, c, neg};
	endtask
	task automatic wait_alarm(input logic want, input int n);
		for (int i = 0; i < n && alarm !== want; i++) @(negedge clk);
		check(alarm, want, "alarm");
	endtask
	// full wait: a quiet output must stay quiet, not just be quiet now
	task automatic hold_alarm(input logic want);
		repeat (3 * PER) @(negedge clk);
		check(alarm, want, "alarm held");
	endtask
	////////////////////////////////////////
	task automatic t_alarm;
		meas(16'h0032, 16'h0032, 16'h0000, 16'h0000);
		repeat (5 * PER) @(negedge clk);
		check(alarm, 1'b0, "alarm without sequence");
		meas(16'h0032, 16'h0032, 16'h0000, 16'h003c);
		@(posedge meas_valid);
		repeat (8) @(negedge clk);
		check(alarm, 1'b0, "alarm before delay");
		wait_alarm(1'b1, 40);
		check(alarm_count, 16'h0001, "alarm count");
		check(prefault_a, 16'h0032, "prefault a");
		check(prefault_b, 16'h0032, "prefault b");
		check(prefault_c, 16'h0000, "prefault c");
	endtask
	task automatic t_cond;
		logic [63:0] bad [5];
		bad = '{64'h0082_0032_0000_003c, 64'h0005_0005_0000_003c, 64'h0078_0078_000b_003c,
			64'h0032_0032_0009_003c, 64'h0032_0032_0000_0028};
		for (int i = 0; i < 5; i++) begin
			meas(bad[i][63:48], bad[i][47:32], bad[i][31:16], bad[i][15:0]);
			hold_alarm(1'b0);
			meas(16'h0032, 16'h0032, 16'h0000, 16'h003c);
			wait_alarm(1'b1, 3 * PER);
		end
	endtask
	task automatic t_hyst;
		meas(16'h0079, 16'h0032, 16'h0000, 16'h003c);
		hold_alarm(1'b0);
		meas(16'h0077, 16'h0032, 16'h0000, 16'h003c);
		hold_alarm(1'b0);
		meas(16'h0074, 16'h0032, 16'h0000, 16'h003c);
		wait_alarm(1'b1, 3 * PER);
	endtask
	task automatic t_residual;
		// phase sum of 100 so a subtracted residual of 100 cancels it
		meas(16'h0032, 16'h0032, 16'h0000, 16'h003c);
		{res_sel, polarity, meas_val[3], meas_val[4]} = {CCS_RES_A, 1'b1, 16'h0064, 16'h0064};
		hold_alarm(1'b0);
		polarity = 1'b0;
		wait_alarm(1'b1, 3 * PER);
		{res_sel, polarity, meas_val[3]} = {CCS_RES_B, 1'b1, 16'h0000};
		hold_alarm(1'b0);
		res_sel = CCS_RES_NONE;
		wait_alarm(1'b1, 3 * PER);
	endtask
	task automatic t_block;
		logic [31:0] t0;
		block_in = 1'b1;
		for (int i = 0; i < 6 && blocked !== 1'b1; i++) @(negedge clk);
		check({blocked, alarm, evt_valid}, 3'h5, "block reaction");
		check({evt_source, evt_level}, 4'he, "block event");
		check(blocked_count, 16'h0001, "blocked count");
		t0 = evt_time;
		hold_alarm(1'b0);
		block_in = 1'b0;
		for (int i = 0; i < 6 && blocked !== 1'b0; i++) @(negedge clk);
		// release event lands exactly 153 cycles, so 15 ms ticks, after the raise
		check(evt_valid, 1'b1, "unblock event");
		check(evt_time - t0, 32'h0000_000f, "event time step");
		repeat (8) @(negedge clk);
		check(alarm, 1'b0, "alarm right after unblock");
		wait_alarm(1'b1, 3 * PER);
	endtask
	task automatic t_group;
		cfg(3'h3, CCS_FLD_SEQ, 16'h2328);
		cfg(3'h3, CCS_FLD_DELAY, 16'h0002);
		cfg(3'h0, 3'h6, 16'h0000);
		group_sel = 3'h3;
		hold_alarm(1'b0);
		group_sel = 3'h0;
		wait_alarm(1'b1, 3 * PER);
	endtask
	task automatic t_clear;
		cnt_clear = 1'b1;
		@(negedge clk);
		cnt_clear = 1'b0;
		check({alarm_count, blocked_count}, 32'h0, "counts after clear");
	endtask
	////////////////////////////////////////
	initial begin
		{clk, rst_n, block_in, polarity, cfg_we, cnt_clear} = '0;
		{group_sel, cfg_group, cfg_field, res_sel, cfg_data} = '0;
		meas_val = '0;
		meas_val[5] = 16'h0064;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		check({30'h0, alarm, blocked}, 32'h0, "reset outputs");
		check({alarm_count, blocked_count}, 32'h0, "reset counts");
		repeat (4) @(negedge clk);
		cfg(3'h0, CCS_FLD_DELAY, 16'h0002);
		t_alarm();
		t_cond();
		t_hyst();
		t_residual();
		t_block();
		t_group();
		t_clear();
		stop_test();
	end
	// about sixteen times the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
endmodule

bind ccs_supervision ccs_sup_assertions u_chk (
	.CLK(CLK),
	.RST_N(RST_N),
	.BLOCK_IN(BLOCK_IN),
	.CNT_CLEAR(CNT_CLEAR),
	.ALARM(ALARM),
	.BLOCKED(BLOCKED),
	.EVT_VALID(EVT_VALID),
	.EVT_SOURCE(EVT_SOURCE),
	.EVT_LEVEL(EVT_LEVEL),
	.ALARM_COUNT(ALARM_COUNT),
	.BLOCKED_COUNT(BLOCKED_COUNT)
);
